// >>> design/fcc_defs.vh
// Constants for the flash charger control block.
// Assumes a 40 MHz system clock; counts derive from times in ns.
`ifndef FCC_DEFS_VH
`define FCC_DEFS_VH
// ==========================================================
// Clock
`define FCC_CLK_PERIOD_NS 25
// ==========================================================
// Times as printed
`define FCC_START_DELAY_US 12
`define FCC_STOP_DELAY_NS 20
`define FCC_DONE_DELAY_NS 400
`define FCC_FLASH_DELAY_NS 50
`define FCC_PEAK_DELAY_NS 270
`define FCC_ZERO_DELAY_NS 45
`define FCC_MAX_ON_US 100
`define FCC_MAX_OFF_US 50
// ==========================================================
// Cycle counts (typical figures, rounded down, at least one)
`define FCC_START_CYC ((`FCC_START_DELAY_US*1000)/`FCC_CLK_PERIOD_NS)
`define FCC_DONE_CYC (`FCC_DONE_DELAY_NS/`FCC_CLK_PERIOD_NS)
`define FCC_FLASH_CYC (`FCC_FLASH_DELAY_NS/`FCC_CLK_PERIOD_NS)
`define FCC_PEAK_CYC (`FCC_PEAK_DELAY_NS/`FCC_CLK_PERIOD_NS)
`define FCC_ZERO_CYC (`FCC_ZERO_DELAY_NS/`FCC_CLK_PERIOD_NS)
`define FCC_MAX_ON_CYC ((`FCC_MAX_ON_US*1000)/`FCC_CLK_PERIOD_NS)
`define FCC_MAX_OFF_CYC ((`FCC_MAX_OFF_US*1000)/`FCC_CLK_PERIOD_NS)
`define FCC_CNT_W 18
`endif

// >>> design/fcc_sync.v
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes inputs come from pins or analog comparators.
`timescale 1ns/1ps
module fcc_sync #(
    parameter W = 1
) (
    sys_clk,
    rstSync_b,
    asyncIn,
    syncOut
);
    input wire sys_clk;
    input wire rstSync_b;
    input wire [W-1:0] asyncIn;
    output reg [W-1:0] syncOut;
    reg [W-1:0] meta;
    // First stage feeds the second stage only
    always @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            meta <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            meta <= asyncIn;
            syncOut <= meta;
        end
    end
endmodule // fcc_sync

// >>> design/fcc_control.v
// Flash charger control: enable latch, switch timing, done and flash gate.
// Assumes comparator results and host pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`include "fcc_defs.vh"
module fcc_control #(
    parameter [`FCC_CNT_W-1:0] START_CYC = `FCC_START_CYC,
    parameter [`FCC_CNT_W-1:0] MAX_ON_CYC = `FCC_MAX_ON_CYC,
    parameter [`FCC_CNT_W-1:0] MAX_OFF_CYC = `FCC_MAX_OFF_CYC
) (
    sys_clk,
    rst_b,
    chargeRequest,
    flashTrigger,
    fullChargeCmp,
    zeroVoltageCmp,
    currentCmp,
    overvoltageCmp,
    primarySwitchOn,
    flashGateDrive,
    chargeDoneOut,
    chargeDoneOe,
    enableLatch,
    faultLatched
);
    input wire sys_clk;
    input wire rst_b;
    input wire chargeRequest;
    input wire flashTrigger;
    input wire fullChargeCmp;
    input wire zeroVoltageCmp;
    input wire currentCmp;
    input wire overvoltageCmp;
    output wire primarySwitchOn;
    output reg flashGateDrive;
    output wire chargeDoneOut;
    output wire chargeDoneOe;
    output reg enableLatch;
    output reg faultLatched;

    // ==========================================================
    // Reset release and input synchronisers
    reg [1:0] rstPipe;
    wire rstSync_b;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe[1];

    wire [5:0] syncIn;
    fcc_sync #(
        .W(6)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstSync_b(rstSync_b),
        .asyncIn({chargeRequest, flashTrigger, fullChargeCmp,
                  zeroVoltageCmp, currentCmp, overvoltageCmp}),
        .syncOut(syncIn)
    );
    wire reqS = syncIn[5];
    wire trigS = syncIn[4];
    wire fullS = syncIn[3];
    wire zeroS = syncIn[2];
    wire peakS = syncIn[1];
    wire ovS = syncIn[0];

    reg reqPrev;
    wire reqRise = reqS & ~reqPrev;
    wire reqFall = ~reqS & reqPrev;

    // ==========================================================
    // Switch phase machine
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_ON = 2'h2;
    localparam [1:0] ST_OFF = 2'h3;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`FCC_CNT_W-1:0] phaseCnt;
    reg [`FCC_CNT_W-1:0] next_phaseCnt;
    reg [3:0] evtCnt;
    reg [3:0] next_evtCnt;
    reg [4:0] doneCnt;
    reg doneLow;
    reg [1:0] flashCnt;

    function [3:0] fccDelayStep;
        input evt;
        input [3:0] cnt;
        input [3:0] lim;
        begin
            fccDelayStep = evt ? ((cnt < lim) ? cnt + 4'h1 : cnt) : 4'h0;
        end
    endfunction

    // Counts are cut to their counter widths on purpose
    localparam integer PEAK_I = `FCC_PEAK_CYC;
    localparam integer ZERO_I = `FCC_ZERO_CYC;
    localparam integer DONE_I = `FCC_DONE_CYC;
    localparam integer FLASH_I = `FCC_FLASH_CYC;
    localparam [3:0] PEAK_CYC = PEAK_I[3:0];
    localparam [3:0] ZERO_CYC = ZERO_I[3:0];
    localparam [4:0] DONE_CYC = DONE_I[4:0];
    localparam [1:0] FLASH_CYC = FLASH_I[1:0];

    // Fault counts only while the switch really conducts, so a request
    // drop in the last ON cycle cannot latch a false fault
    wire ovTrip = primarySwitchOn & ovS;
    // Stop terms act in the same cycle; the switch output is gated
    // combinationally so a request drop cuts it within one edge.
    wire stopNow = ~reqS | fullS | faultLatched | ovTrip;

    always @* begin
        next_state = state;
        next_phaseCnt = phaseCnt + 1'b1;
        next_evtCnt = evtCnt;
        case (state)
            ST_IDLE: begin
                next_phaseCnt = {`FCC_CNT_W{1'b0}};
                next_evtCnt = 4'h0;
                if (reqRise) begin
                    next_state = ST_START;
                end
            end
            ST_START: begin
                if (phaseCnt >= START_CYC - 1'b1) begin
                    next_state = ST_ON;
                    next_phaseCnt = {`FCC_CNT_W{1'b0}};
                end
            end
            ST_ON: begin
                next_evtCnt = fccDelayStep(peakS, evtCnt, PEAK_CYC);
                if ((peakS && evtCnt >= PEAK_CYC - 4'h1) ||
                    phaseCnt >= MAX_ON_CYC - 1'b1) begin
                    next_state = ST_OFF;
                    next_phaseCnt = {`FCC_CNT_W{1'b0}};
                    next_evtCnt = 4'h0;
                end
            end
            ST_OFF: begin
                next_evtCnt = fccDelayStep(zeroS, evtCnt, ZERO_CYC);
                if ((zeroS && evtCnt >= ZERO_CYC - 4'h1) ||
                    phaseCnt >= MAX_OFF_CYC - 1'b1) begin
                    next_state = ST_ON;
                    next_phaseCnt = {`FCC_CNT_W{1'b0}};
                    next_evtCnt = 4'h0;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (state != ST_IDLE && stopNow) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state <= ST_IDLE;
            phaseCnt <= {`FCC_CNT_W{1'b0}};
            evtCnt <= 4'h0;
            reqPrev <= 1'b0;
            enableLatch <= 1'b0;
            faultLatched <= 1'b0;
        end else begin
            state <= next_state;
            phaseCnt <= next_phaseCnt;
            evtCnt <= next_evtCnt;
            reqPrev <= reqS;
            // Single latch: rising edge sets, a stop event clears unless it meets a rising edge
            if (reqRise) begin
                enableLatch <= 1'b1;
            end else if (stopNow) begin
                enableLatch <= 1'b0;
            end
            // Fault holds until the next request cycle begins
            if (reqRise) begin
                faultLatched <= 1'b0;
            end else if (ovTrip) begin
                faultLatched <= 1'b1;
            end
        end
    end

    assign primarySwitchOn = (state == ST_ON) & reqS & enableLatch;

    // ==========================================================
    // Charge done indicator (open drain)
    always @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            doneCnt <= 5'h0;
            doneLow <= 1'b0;
        end else begin
            if (reqFall || reqRise) begin
                doneLow <= 1'b0;
                doneCnt <= 5'h0;
            end else if (faultLatched) begin
                doneLow <= 1'b0;
                doneCnt <= 5'h0;
            end else if (reqS && fullS) begin
                // Full clears the latch at once, so the count cannot
                // wait on it; host then times the charge
                if (doneCnt >= DONE_CYC - 5'h1) begin
                    doneLow <= 1'b1;
                end else begin
                    doneCnt <= doneCnt + 5'h1;
                end
            end else begin
                doneCnt <= 5'h0;
            end
        end
    end
    assign chargeDoneOut = 1'b0;
    assign chargeDoneOe = doneLow & ~faultLatched;

    // ==========================================================
    // Flash gate drive, a short filter standing for the gate delay
    always @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            flashGateDrive <= 1'b0;
            flashCnt <= 2'h0;
        end else if (reqS) begin
            flashGateDrive <= 1'b0;
            flashCnt <= 2'h0;
        end else if (trigS != flashGateDrive) begin
            if (flashCnt >= FLASH_CYC - 2'h1) begin
                flashGateDrive <= trigS;
                flashCnt <= 2'h0;
            end else begin
                flashCnt <= flashCnt + 2'h1;
            end
        end else begin
            flashCnt <= 2'h0;
        end
    end
endmodule // fcc_control

// >>> tb/fcc_chk.sv
// Port checker for fcc_control.
// Assumes it is bound onto fcc_control and sees only its ports.
`timescale 1ns/1ps
module fcc_chk #(
    parameter [17:0] MAX_ON_CYC = 18'h00028
) (
    input wire sys_clk,
    input wire rst_b,
    input wire chargeRequest,
    input wire flashTrigger,
    input wire fullChargeCmp,
    input wire primarySwitchOn,
    input wire flashGateDrive,
    input wire chargeDoneOe,
    input wire enableLatch,
    input wire faultLatched
);
    reg [17:0] onCnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // On-phase length, counted because it is too long to unroll
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            onCnt <= 18'h00000;
        else
            onCnt <= primarySwitchOn ? onCnt + 18'h00001 : 18'h00000;
    end
    a_on_time_limit: assert property (
        onCnt <= MAX_ON_CYC + 18'h00002)
        else $error("on phase too long");
    a_latch_start: assert property (
        $rose(enableLatch) |-> chargeRequest && $past(chargeRequest, 2))
        else $error("latch set without request rise");
    a_req_low_off: assert property (
        !chargeRequest [*3] |-> !primarySwitchOn)
        else $error("switch on with request low");
    a_switch_latch: assert property (
        primarySwitchOn |-> enableLatch)
        else $error("switch on with latch clear");
    a_fault_stop: assert property (
        faultLatched |-> !primarySwitchOn)
        else $error("switching while faulted");
    a_fault_on_only: assert property (
        $rose(faultLatched) |-> $past(primarySwitchOn))
        else $error("fault latched in off phase");
    a_full_stop: assert property (
        fullChargeCmp [*4] |-> !primarySwitchOn)
        else $error("switching after full charge");
    a_done_cause: assert property (
        $rose(chargeDoneOe) |->
            $past(fullChargeCmp, 3) && $past(fullChargeCmp, 15))
        else $error("done without held full");
    a_done_quiet: assert property (
        enableLatch || faultLatched |-> !chargeDoneOe)
        else $error("done while charging or faulted");
    a_done_release: assert property (
        !chargeRequest [*5] |-> !chargeDoneOe)
        else $error("done held after request low");
    a_gate_high: assert property (
        (!chargeRequest && flashTrigger) [*8] |-> flashGateDrive)
        else $error("gate not following high trigger");
    a_gate_low: assert property (
        !flashTrigger [*8] |-> !flashGateDrive)
        else $error("gate not following low trigger");
endmodule // fcc_chk
bind fcc_control fcc_chk #(.MAX_ON_CYC(MAX_ON_CYC)) i_chk (.sys_clk,
    .rst_b, .chargeRequest, .flashTrigger, .fullChargeCmp, .primarySwitchOn,
    .flashGateDrive, .chargeDoneOe, .enableLatch, .faultLatched);

// >>> tb/fcc_host.sv
// Host controller model driving the request and trigger pins.
// Assumes the done pin is pulled up outside; bench sets goCharge and fire.
`timescale 1ns/1ps
module fcc_host #(
    parameter MAX_CHARGE = 300
) (
    input wire sys_clk,
    input wire goCharge,
    input wire fire,
    input wire chargeDonePin,
    output logic chargeRequest,
    output logic flashTrigger,
    output logic timedOut
);
    int timer = 0;
    logic goSeen, fireSeen, doneSeen;
    initial chargeRequest = 1'b0;
    initial flashTrigger = 1'b0;
    initial timedOut = 1'b0;
    // Inputs are taken at the edge and pins move 1 ns later, so this
    // model never races the bench, which also drives 1 ns after the edge
    // Host only fires after a cycle with request low, as a real camera would
    always @(posedge sys_clk) begin
        goSeen = goCharge;
        fireSeen = fire;
        doneSeen = chargeDonePin;
        #1;
        timer <= (chargeRequest && doneSeen) ? timer + 1 : 0;
        if (!goSeen)
            timedOut <= 1'b0;
        else if (timer == MAX_CHARGE)
            timedOut <= 1'b1;
        chargeRequest <= goSeen && !timedOut &&
            timer != MAX_CHARGE;
        flashTrigger <= fireSeen && !chargeRequest;
    end
endmodule // fcc_host

// >>> tb/tb_top.sv
// Self-checking bench for fcc_control with a host model.
// Assumes comparator results are driven here; the done pin has a pull-up.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rst_b, goCharge, fire, fullCmp, zeroCmp, curCmp, ovCmp;
    wire chargeRequest, flashTrigger, timedOut, swOn, gate, doneOut;
    wire doneOe, latch, fault, donePin;
    logic [4:0] expQ[$];
    int bad_count, checks_done, seed, i;
    event smp;
    assign donePin = doneOe ? doneOut : 1'b1;
    fcc_control #(.START_CYC(18'h00008), .MAX_ON_CYC(18'h00028),
        .MAX_OFF_CYC(18'h00014)) i_dut (.sys_clk, .rst_b, .chargeRequest,
        .flashTrigger, .fullChargeCmp(fullCmp), .zeroVoltageCmp(zeroCmp),
        .currentCmp(curCmp), .overvoltageCmp(ovCmp), .primarySwitchOn(swOn),
        .flashGateDrive(gate), .chargeDoneOut(doneOut),
        .chargeDoneOe(doneOe), .enableLatch(latch), .faultLatched(fault));
    fcc_host i_host (.sys_clk, .goCharge, .fire, .chargeDonePin(donePin),
        .chargeRequest, .flashTrigger, .timedOut);
    // ==========================================================
    // Tasks
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wait_on(input int max);
        for (i = 0; i < max && swOn !== 1'b1; i++) step(1);
    endtask
    // Vector is {switch, latch, fault, done pin, gate}
    task note(input logic [4:0] v);
        expQ.push_back(v);
        ->smp;
    endtask
    task compare(input logic [4:0] seen, input logic [4:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch outputs exp %b seen %b", exp, seen);
        end
    endtask
    always @(smp) compare({swOn, latch, fault, donePin, gate}, expQ.pop_front());
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #(25 * 4000);
        bad_count++;
        close_out;
    end
    initial begin
        seed = 17;
        {rst_b, goCharge, fire, fullCmp, zeroCmp, curCmp, ovCmp} = 7'h00;
        step(10);
        rst_b = 1'b1;
        step(4);
        goCharge = 1'b1;
        wait_on(30);
        note(5'h1a);
        curCmp = 1'b1;
        step(14);
        note(5'h0a);
        ovCmp = 1'b1;
        step(3);
        {ovCmp, curCmp, zeroCmp} = 3'h1;
        note(5'h0a);
        step(4);
        zeroCmp = 1'b0;
        note(5'h1a);
        step(42);
        note(5'h0a);
        step(21);
        note(5'h1a);
        $display("test switching done");
        fullCmp = 1'b1;
        step(4);
        note(5'h02);
        step(18);
        note(5'h00);
        {goCharge, fullCmp} = 2'h0;
        step(5);
        note(5'h02);
        $display("test full charge done");
        goCharge = 1'b1;
        wait_on(30);
        ovCmp = 1'b1;
        step(4);
        {ovCmp, fullCmp} = 2'h1;
        note(5'h06);
        step(22);
        note(5'h06);
        fullCmp = 1'b0;
        for (i = 0; i < 400 && timedOut !== 1'b1; i++) step(1);
        compare({4'h0, timedOut}, 5'h01);
        goCharge = 1'b0;
        step(2);
        goCharge = 1'b1;
        wait_on(40);
        note(5'h1a);
        $display("test fault done");
        goCharge = 1'b0;
        step(6);
        for (int k = 0; k < 8; k++) begin
            fire = ($random(seed) % 2) != 0;
            step(8);
            note({4'h1, fire});
        end
        $display("test flash done");
        close_out;
    end
endmodule // tb_top
